// ---- verilog/sod_pkg.sv ----
// constants and types shared by the safety output off-delay block
`default_nettype none
package sod_pkg;

  localparam int unsigned CLK_HZ = 200000000;
  localparam int unsigned TICK_MS = 100;
  localparam int unsigned TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;

  localparam logic [3:0] POS_MIN = 4'h1;
  localparam logic [3:0] APP_POS_MAX = 4'h8;
  localparam logic [3:0] START_POS_MAX = 4'h8;
  localparam logic [3:0] BASE_POS_MAX = 4'h8;
  localparam logic [3:0] BASE_EXT_DELAYED_POS = 4'h5;
  localparam logic [3:0] FACTOR_POS_MAX = 4'ha;
  localparam logic [1:0] START_MONITORED_BIT = 2'h1;
  localparam logic [8:0] APP_NO_MONITORED_MASK = 9'h000;

  localparam int DELAY_W = 14;
  localparam logic [DELAY_W-1:0] BASE_1 = 14'h0001;
  localparam logic [DELAY_W-1:0] BASE_10 = 14'h000a;
  localparam logic [DELAY_W-1:0] BASE_100 = 14'h0064;
  localparam logic [DELAY_W-1:0] BASE_1000 = 14'h03e8;
  localparam int TICK_W = 25;
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;

  typedef struct packed {
    logic [3:0] app;
    logic [3:0] start;
    logic [3:0] base;
    logic [3:0] factor;
  } sod_sel_type;

  typedef struct packed {
    logic safety;
    logic cancel_a;
    logic cancel_b;
  } sod_in_type;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_ACTIVE,
    ST_DELAY
  } sod_state_type;

endpackage
`default_nettype wire

// ---- verilog/sod_off_delay.sv ----
// off-delay timer for the delayed safety outputs
//
// Contract
// - delayed outputs stay on after inputs drop until the delay has elapsed
// - delay in seconds is base value times factor
// - factor positions 1..10 give 0.0..0.9; position 1 means no delay
// - base positions 1..4: 1,10,100,1000, extension outputs drop at once
// - base positions 5..8: 1,10,100,1000, extension outputs also delayed
// - active cancel input of the chosen pair aborts the delay, outputs off
// - safe state is all outputs off; it ends every delay
// - technically incompatible configurations raise a configuration error
// - selectors sampled at power-up; any later change is a configuration error
`timescale 1ns/10ps
`default_nettype none
module sod_off_delay
  import sod_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic resetn,
  input wire sod_in_type in_pins,
  input wire sod_sel_type sel_pins,
  output logic delayed_out,
  output logic ext_out,
  output logic config_error,
  output logic delay_running
);

  function automatic logic [DELAY_W-1:0] base_value(input logic [3:0] pos);
    unique case (pos)
      4'h1, 4'h5: base_value = BASE_1;
      4'h2, 4'h6: base_value = BASE_10;
      4'h3, 4'h7: base_value = BASE_100;
      default: base_value = BASE_1000;
    endcase
  endfunction

  function automatic logic incompatible(input sod_sel_type s);
    logic bad_range;
    bad_range = (s.app < POS_MIN) || (s.app > APP_POS_MAX) ||
                (s.start < POS_MIN) || (s.start > START_POS_MAX) ||
                (s.base < POS_MIN) || (s.base > BASE_POS_MAX) ||
                (s.factor < POS_MIN) || (s.factor > FACTOR_POS_MAX);
    // monitored start on an application that cannot support it
    incompatible = bad_range ||
      (((s.start - POS_MIN) & {2'h0, START_MONITORED_BIT}) != 4'h0 &&
       APP_NO_MONITORED_MASK[s.app]);
  endfunction

  // pin synchronisers: stage 1 read only by stage 2
  sod_in_type in_s1_r, in_s2_r;
  sod_sel_type sel_s1_r, sel_s2_r;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      in_s1_r <= '0;
      in_s2_r <= '0;
      sel_s1_r <= '0;
      sel_s2_r <= '0;
    end else begin
      in_s1_r <= in_pins;
      in_s2_r <= in_s1_r;
      sel_s1_r <= sel_pins;
      sel_s2_r <= sel_s1_r;
    end
  end

  // configuration capture at power-up
  logic [1:0] settle_r, settle_nxt;
  logic sampled_r, sampled_nxt;
  sod_sel_type cfg_r, cfg_nxt;
  logic err_r, err_nxt;
  logic [DELAY_W-1:0] delay_ticks;
  logic ext_delayed;
  logic cancel_now;

  always_comb begin
    settle_nxt = settle_r;
    sampled_nxt = sampled_r;
    cfg_nxt = cfg_r;
    err_nxt = err_r;
    if (!sampled_r) begin
      // wait until the synchronisers hold real pin values
      if (settle_r == SETTLE_CYCLES) begin
        sampled_nxt = 1'b1;
        cfg_nxt = sel_s2_r;
        err_nxt = incompatible(sel_s2_r);
      end else begin
        settle_nxt = settle_r + 2'h1;
      end
    end else if (sel_s2_r != cfg_r || incompatible(cfg_r)) begin
      err_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      settle_r <= 2'h0;
      sampled_r <= 1'b0;
      cfg_r <= '0;
      err_r <= 1'b0;
    end else begin
      settle_r <= settle_nxt;
      sampled_r <= sampled_nxt;
      cfg_r <= cfg_nxt;
      err_r <= err_nxt;
    end
  end

  // delay in 0.1 s ticks equals base times factor tenths
  assign delay_ticks = DELAY_W'(base_value(cfg_r.base) * DELAY_W'(cfg_r.factor - POS_MIN));
  assign ext_delayed = (cfg_r.base >= BASE_EXT_DELAYED_POS);
  // odd application positions cancel on pair a, even ones on pair b
  assign cancel_now = cfg_r.app[0] ? in_s2_r.cancel_a : in_s2_r.cancel_b;

  // output state machine and tick divider
  sod_state_type state_r, state_nxt;
  logic [DELAY_W-1:0] remain_r, remain_nxt;
  logic [TICK_W-1:0] div_r, div_nxt;
  logic tick;
  logic dly_r, dly_nxt;
  logic ext_r, ext_nxt;

  assign tick = (div_r == TICK_W'(TICK_CYCLES - 1));

  always_comb begin
    state_nxt = state_r;
    remain_nxt = remain_r;
    div_nxt = tick ? '0 : div_r + TICK_W'(1);
    if (err_r || !sampled_r) begin
      state_nxt = ST_OFF;
    end else begin
      unique case (state_r)
        ST_OFF: begin
          if (in_s2_r.safety) begin
            state_nxt = ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          if (!in_s2_r.safety) begin
            if (delay_ticks == '0) begin
              state_nxt = ST_OFF;
            end else begin
              state_nxt = ST_DELAY;
              remain_nxt = delay_ticks;
              // restart the divider so the first tick is a full one
              div_nxt = '0;
            end
          end
        end
        ST_DELAY: begin
          if (cancel_now) begin
            state_nxt = ST_OFF;
          end else if (tick) begin
            if (remain_r == DELAY_W'(1)) begin
              state_nxt = ST_OFF;
            end
            remain_nxt = remain_r - DELAY_W'(1);
          end
        end
      endcase
    end
    dly_nxt = (state_nxt != ST_OFF);
    ext_nxt = (state_nxt == ST_ACTIVE) || (state_nxt == ST_DELAY && ext_delayed);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_r <= ST_OFF;
      remain_r <= '0;
      div_r <= '0;
      dly_r <= 1'b0;
      ext_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      remain_r <= remain_nxt;
      div_r <= div_nxt;
      dly_r <= dly_nxt;
      ext_r <= ext_nxt;
    end
  end

  assign delayed_out = dly_r;
  assign ext_out = ext_r;
  assign config_error = err_r;
  assign delay_running = (state_r == ST_DELAY);

  property p_fall_cause;
    @(posedge clk) disable iff (!resetn)
    $fell(dly_r) |-> $past(err_r) || $past(cancel_now) || ($past(tick) && $past(remain_r) == DELAY_W'(1)) ||
      ($past(state_r) == ST_ACTIVE && $past(delay_ticks) == '0);
  endproperty
  a_fall_cause: assert property (p_fall_cause) else $error("delayed output dropped early");

  property p_delay_load;
    @(posedge clk) disable iff (!resetn)
    (state_r == ST_ACTIVE && !in_s2_r.safety && !err_r && delay_ticks != '0)
      |=> state_r == ST_DELAY && remain_r == $past(delay_ticks) && dly_r;
  endproperty
  a_delay_load: assert property (p_delay_load) else $error("delay not loaded");

  property p_factor_zero;
    @(posedge clk) disable iff (!resetn)
    (state_r == ST_ACTIVE && !in_s2_r.safety && cfg_r.factor == POS_MIN) |=> !dly_r && !ext_r && state_r == ST_OFF;
  endproperty
  a_factor_zero: assert property (p_factor_zero) else $error("factor one did not drop at once");

  property p_ext_instant;
    @(posedge clk) disable iff (!resetn)
    (state_r == ST_DELAY && cfg_r.base < BASE_EXT_DELAYED_POS) |-> !ext_r;
  endproperty
  a_ext_instant: assert property (p_ext_instant) else $error("extension output held in delay");

  property p_ext_delayed;
    @(posedge clk) disable iff (!resetn)
    (cfg_r.base >= BASE_EXT_DELAYED_POS && sampled_r) |-> ext_r == dly_r;
  endproperty
  a_ext_delayed: assert property (p_ext_delayed) else $error("extension output not following delay");

  property p_cancel;
    @(posedge clk) disable iff (!resetn)
    (state_r == ST_DELAY && cancel_now) |=> !dly_r && !ext_r && state_r == ST_OFF;
  endproperty
  a_cancel: assert property (p_cancel) else $error("cancel did not end delay");

  property p_safe_on_error;
    @(posedge clk) disable iff (!resetn)
    err_r |=> !dly_r && !ext_r;
  endproperty
  a_safe_on_error: assert property (p_safe_on_error) else $error("outputs on with config error");

  property p_incompat;
    @(posedge clk) disable iff (!resetn)
    (sampled_r && incompatible(cfg_r)) |=> err_r;
  endproperty
  a_incompat: assert property (p_incompat) else $error("incompatible configuration not flagged");

  property p_sel_change;
    @(posedge clk) disable iff (!resetn)
    (sampled_r && sel_s2_r != cfg_r) |=> err_r && cfg_r == $past(cfg_r);
  endproperty
  a_sel_change: assert property (p_sel_change) else $error("selector change not flagged");

  property p_tick_step;
    @(posedge clk) disable iff (!resetn)
    (state_r == ST_DELAY && tick && !cancel_now && !err_r && remain_r > DELAY_W'(1))
      |=> remain_r == $past(remain_r) - DELAY_W'(1) && state_r == ST_DELAY;
  endproperty
  a_tick_step: assert property (p_tick_step) else $error("delay count step wrong");

endmodule
`default_nettype wire

// ---- tb/sod_field_model.sv ----
// field-side model: safety sensors and cancel source
`timescale 1ns/10ps
`default_nettype none
module sod_field_model
  import sod_pkg::*;
(
  input wire logic clk,
  input wire logic safety_cmd,
  input wire logic cancel_a_cmd,
  input wire logic cancel_b_cmd,
  output var sod_in_type in_pins
);
  // contacts move one edge after the command; one process drives them
  always @(posedge clk) begin
    in_pins.safety <= safety_cmd;
    in_pins.cancel_a <= cancel_a_cmd;
    in_pins.cancel_b <= cancel_b_cmd;
  end
endmodule
`default_nettype wire

// ---- tb/sod_off_delay_tb.sv ----
// self-checking bench for the off-delay timer
`timescale 1ns/10ps
`default_nettype none
module sod_off_delay_tb
  import sod_pkg::*;
;
  // short tick keeps long delays inside the run budget
  localparam int unsigned TC = 10;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic safety_cmd = 1'b0;
  logic cancel_a_cmd = 1'b0;
  logic cancel_b_cmd = 1'b0;
  sod_sel_type sel = '{app: 4'h1, start: 4'h1, base: 4'h5, factor: 4'h1};
  sod_in_type in_pins;
  logic delayed_out, ext_out, config_error, delay_running;
  int failures = 0;
  int compares = 0;
  int bv[4] = '{1, 10, 100, 1000};
  logic [3:0] bad_base[3] = '{4'h9, 4'h5, 4'h5};
  logic [3:0] bad_fac[3] = '{4'h2, 4'hb, 4'h0};
  int n;

  sod_field_model u_field (.clk(clk), .safety_cmd(safety_cmd), .cancel_a_cmd(cancel_a_cmd),
    .cancel_b_cmd(cancel_b_cmd), .in_pins(in_pins));
  sod_off_delay #(.TICK_CYCLES(TC)) u_dut (.clk(clk), .resetn(resetn), .in_pins(in_pins),
    .sel_pins(sel), .delayed_out(delayed_out), .ext_out(ext_out), .config_error(config_error),
    .delay_running(delay_running));

  always #2.5 clk = ~clk;

  task automatic chk(input logic got, input logic exp, input string msg);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic chk_n(input int got, input int lo, input int hi, input string msg);
    compares++;
    if (got < lo || got > hi) begin
      failures++;
      $display("BAD %0t %s %0d", $time, msg, got);
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wait_out(input logic v, input int lim, output int k);
    k = 0;
    while (delayed_out !== v) begin
      @(posedge clk);
      #1;
      k++;
      if (k > lim) begin
        failures++;
        $display("BAD %0t wait timed out", $time);
        end_of_test();
      end
    end
  endtask

  // selectors only count when captured after reset
  task automatic boot(input logic [3:0] app, input logic [3:0] base, input logic [3:0] fac);
    @(posedge clk);
    resetn <= 1'b0;
    safety_cmd <= 1'b0;
    cancel_a_cmd <= 1'b0;
    cancel_b_cmd <= 1'b0;
    sel <= '{app: app, start: 4'h1, base: base, factor: fac};
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
    safety_cmd <= 1'b1;
    #1;
  endtask

  task automatic run(input logic [3:0] app, input logic [3:0] base, input logic [3:0] fac, input bit cancel);
    int d;
    int m;
    d = bv[(int'(base) - 1) % 4] * (int'(fac) - 1) * TC;
    m = 0;
    boot(app, base, fac);
    wait_out(1'b1, 20, n);
    chk(ext_out, 1'b1, "ext not on");
    chk(config_error, 1'b0, "false config error");
    @(posedge clk);
    safety_cmd <= 1'b0;
    #1;
    if (d > 0) begin
      repeat (8) @(posedge clk);
      #1;
      m = 8;
      chk(delayed_out, 1'b1, "dropped early");
      chk(delay_running, 1'b1, "no delay state");
      chk(ext_out, base >= BASE_EXT_DELAYED_POS, "ext wrong");
    end
    if (cancel) begin
      // the other pair must not cancel
      @(posedge clk);
      cancel_a_cmd <= ~app[0];
      cancel_b_cmd <= app[0];
      repeat (8) @(posedge clk);
      #1;
      chk(delayed_out, 1'b1, "wrong pair cancelled");
      @(posedge clk);
      cancel_a_cmd <= app[0];
      cancel_b_cmd <= ~app[0];
      wait_out(1'b0, 8, n);
    end else begin
      wait_out(1'b0, d + 20, n);
      chk_n(n + m, d + 3, d + 7, "delay length");
    end
    chk(ext_out, 1'b0, "ext left on");
    chk(delay_running, 1'b0, "delay still running");
  endtask

  initial begin
    run(4'h1, 4'h6, 4'h3, 1'b0);
    run(4'h2, 4'h3, 4'h2, 1'b0);
    run(4'h1, 4'h1, 4'h1, 1'b0);
    run(4'h1, 4'h8, 4'h2, 1'b1);
    run(4'h2, 4'h7, 4'h3, 1'b1);
    boot(4'h1, 4'h5, 4'h2);
    wait_out(1'b1, 20, n);
    @(posedge clk);
    sel.factor <= 4'h3;
    repeat (8) @(posedge clk);
    #1;
    chk(config_error, 1'b1, "change not flagged");
    chk(delayed_out, 1'b0, "output on after change");
    chk(ext_out, 1'b0, "ext on after change");
    for (int i = 0; i < 3; i++) begin
      boot(4'h1, bad_base[i], bad_fac[i]);
      repeat (12) @(posedge clk);
      #1;
      chk(config_error, 1'b1, "bad selector missed");
      chk(delayed_out, 1'b0, "output on with bad selector");
    end
    end_of_test();
  end
endmodule
`default_nettype wire
